//--- src/acs_pkg.sv
`default_nettype none

package acs_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] ADDR_CTRL0 = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h04;
   localparam logic [7:0] ADDR_STAGE = 8'h08;
   localparam logic [7:0] ADDR_PRE = 8'h0C;
   localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
   localparam logic [7:0] ADDR_RES_LOW = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

   // converter_control_0 layout: bit 2 rc select, bit 1 start/busy, bit 0 enable
   typedef struct packed {
      logic rc_sel;
      logic go;
      logic enable;
   } acs_ctrl_type;
   localparam int CTRL_W = 3;
   localparam acs_ctrl_type CTRL_RST = '{rc_sel: 1'b0, go: 1'b0, enable: 1'b0};

   // conversion_stage_status layout: bit 2 sequence_active, bits 1:0 sequence_stage
   typedef struct packed {
      logic active;
      logic [1:0] stage;
   } acs_stage_type;
   localparam logic [1:0] STAGE_NONE = 2'h0;
   localparam logic [1:0] STAGE_PRE = 2'h1;
   localparam logic [1:0] STAGE_ACQ = 2'h2;
   localparam logic [1:0] STAGE_CONV = 2'h3;

   // Interrupt status and mask layout
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ABORT_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // trigger_source_select encodings
   localparam int TRIG_SEL_W = 3;
   localparam logic [TRIG_SEL_W-1:0] TRIG_CCP_ONE = 3'h0;
   localparam logic [TRIG_SEL_W-1:0] TRIG_CCP_TWO = 3'h1;
   localparam logic [TRIG_SEL_W-1:0] TRIG_TMR0_OVF = 3'h2;
   localparam logic [TRIG_SEL_W-1:0] TRIG_TMR1_OVF = 3'h3;
   localparam logic [TRIG_SEL_W-1:0] TRIG_TMR2_MATCH = 3'h4;
   localparam int TRIG_SRC_N = 5;
   localparam logic [TRIG_SEL_W-1:0] TRIG_SEL_RST = 3'h0;

   // Timing and widths
   localparam int PRE_W = 7;
   localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
   localparam int INSTR_CLKS = 4;
   localparam int ACQ_TICKS_DEF = 2;
   localparam int RES_W_DEF = 10;
   localparam int LOW_W = 8;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DELAY,
      ST_PRE,
      ST_ACQ,
      ST_CONV
   } acs_state_type;

endpackage

`default_nettype wire

//--- src/acs_tick_counter.sv
`timescale 1ns/1ns
`default_nettype none

// Counts ticks of the stage clock; done pulses on the tick that ends the interval
module acs_tick_counter
   import acs_pkg::*;
#(
   parameter int W = PRE_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   input wire logic tick_i,
   output logic done_o
);

   logic [W-1:0] count;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
      end else if (load_i) begin
         count <= value_i;
      end else if (tick_i && count != '0) begin
         count <= count - 1'b1;
      end
   end

   // Value n ends on the n-th tick after the load, value 0 on the first
   assign done_o = tick_i && (count <= W'(1));

endmodule

`default_nettype wire

//--- src/acs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Writing start=1 with enable set begins a conversion sequence.
// - On completion: clear start, set done flag, load high and low results.
// - Software clearing start aborts; in the conversion stage the partial result is stored, unresolved bits copy last resolved.
// - Reset returns all registers to defaults, converter off, sequence abandoned.
// - With RC clock, start waits one extra instruction cycle for sleep.
// - Completion in sleep with done interrupt enabled wakes the device.
// - Completion in sleep with done interrupt masked powers down, enable stays.
// - Sleep without RC clock aborts conversion and powers down, enable stays.
// - Selected trigger source sets the start bit in hardware.
// - Pre-charge lasts field value in instruction cycles; zero skips it.
// - RC clock selected also times pre-charge and acquisition.
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int RES_W = RES_W_DEF,
   parameter int ACQ_TICKS = ACQ_TICKS_DEF
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [TRIG_SRC_N-1:0] trig_i,
   input wire logic rc_tick_i,
   input wire logic sleep_i,
   input wire logic comp_i,
   output logic [RES_W-1:0] sar_code_o,
   output logic precharge_o,
   output logic sample_o,
   output logic converting_o,
   output logic powered_o,
   output logic wake_o,
   output logic irq_o
);

   localparam int IDX_W = $clog2(RES_W);

   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
      return adr[7:2] == off[7:2];
   endfunction

   // Unresolved bits at and below idx take the value of the last resolved bit
   function automatic logic [RES_W-1:0] fill_partial(input logic [RES_W-1:0] r, input logic [IDX_W-1:0] i);
      logic [RES_W-1:0] f;
      logic lastb;
      f = r;
      lastb = 1'b0;
      if (int'(i) < RES_W - 1) begin
         lastb = r[int'(i) + 1];
      end
      for (int k = 0; k < RES_W; k++) begin
         if (k <= int'(i)) begin
            f[k] = lastb;
         end
      end
      return f;
   endfunction

   acs_ctrl_type ctrl;
   acs_ctrl_type wctl;
   acs_state_type state;
   acs_state_type next_state;
   acs_state_type first_stage;
   acs_stage_type stage_stat;
   logic ack;
   logic [31:0] rdata;
   logic [TRIG_SEL_W-1:0] trig_sel;
   logic [PRE_W-1:0] pre_cycles;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [RES_W-1:0] res;
   logic [RES_W-1:0] result;
   logic [IDX_W-1:0] idx;
   logic [$clog2(INSTR_CLKS)-1:0] div;
   logic instr_tick;
   logic tick;
   logic sleep_q;
   logic sleep_rise;
   logic pd;
   logic req;
   logic acc;
   logic wr;
   logic wr_ctrl0;
   logic trig_hit;
   logic sw_start;
   logic hw_start;
   logic start;
   logic sw_abort;
   logic sleep_kill;
   logic kill;
   logic done_evt;
   logic cnt_load;
   logic cnt_done;
   logic [PRE_W-1:0] cnt_value;
   logic [RES_W-1:0] partial;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: ack one cycle after the request, data registered with it

   assign req = wb_cyc_i && wb_stb_i;
   assign acc = req && ack;
   assign wr = acc && wb_we_i && wb_sel_i[0];
   assign wr_ctrl0 = wr && reg_hit(wb_adr_i, ADDR_CTRL0);
   assign wctl = acs_ctrl_type'(wb_dat_i[CTRL_W-1:0]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !ack;
      end
   end
   assign wb_ack_o = ack;

   always_comb begin
      rdata = 32'h0000_0000;
      if (reg_hit(wb_adr_i, ADDR_CTRL0)) begin
         rdata[CTRL_W-1:0] = ctrl;
      end else if (reg_hit(wb_adr_i, ADDR_CTRL2)) begin
         rdata[TRIG_SEL_W-1:0] = trig_sel;
      end else if (reg_hit(wb_adr_i, ADDR_STAGE)) begin
         rdata[2:0] = stage_stat;
      end else if (reg_hit(wb_adr_i, ADDR_PRE)) begin
         rdata[PRE_W-1:0] = pre_cycles;
      end else if (reg_hit(wb_adr_i, ADDR_RES_HIGH)) begin
         rdata[RES_W-LOW_W-1:0] = result[RES_W-1:LOW_W];
      end else if (reg_hit(wb_adr_i, ADDR_RES_LOW)) begin
         rdata[LOW_W-1:0] = result[LOW_W-1:0];
      end else if (reg_hit(wb_adr_i, ADDR_IRQ_STAT)) begin
         rdata[IRQ_W-1:0] = irq_stat;
      end else if (reg_hit(wb_adr_i, ADDR_IRQ_MASK)) begin
         rdata[IRQ_W-1:0] = irq_mask;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !ack) begin
         wb_dat_o <= rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RST;
      end else begin
         if (wr_ctrl0) begin
            ctrl.enable <= wctl.enable;
            ctrl.rc_sel <= wctl.rc_sel;
         end
         if (start) begin
            ctrl.go <= 1'b1;
         end else if (done_evt || kill) begin
            ctrl.go <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_sel <= TRIG_SEL_RST;
         pre_cycles <= PRE_RST;
         irq_mask <= IRQ_RST;
      end else if (wr) begin
         if (reg_hit(wb_adr_i, ADDR_CTRL2)) begin
            trig_sel <= wb_dat_i[TRIG_SEL_W-1:0];
         end
         if (reg_hit(wb_adr_i, ADDR_PRE)) begin
            pre_cycles <= wb_dat_i[PRE_W-1:0];
         end
         if (reg_hit(wb_adr_i, ADDR_IRQ_MASK)) begin
            irq_mask <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start and abort decisions

   // Out-of-range selects trigger nothing
   assign trig_hit = (int'(trig_sel) < TRIG_SRC_N) ? trig_i[trig_sel] : 1'b0;
   assign sw_start = wr_ctrl0 && wctl.go && wctl.enable;
   assign hw_start = ctrl.enable && trig_hit;
   assign start = (state == ST_IDLE) && (sw_start || hw_start);
   // Turning the converter off also stops the sequence
   assign sw_abort = wr_ctrl0 && (!wctl.go || !wctl.enable) && (state != ST_IDLE);
   assign sleep_rise = sleep_i && !sleep_q;
   assign sleep_kill = sleep_rise && !ctrl.rc_sel && (state != ST_IDLE);
   assign kill = sw_abort || sleep_kill;

   ////////////////////////////////////////////////////////////////////////////
   // Stage timing: instruction cycle or RC tick

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= '0;
      end else if (instr_tick) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end
   assign instr_tick = (int'(div) == INSTR_CLKS - 1);
   assign tick = ctrl.rc_sel ? rc_tick_i : instr_tick;

   assign first_stage = (pre_cycles != '0) ? ST_PRE : ST_ACQ;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start) begin
               // Extra instruction cycle lets a sleep instruction execute first
               next_state = ctrl.rc_sel ? ST_DELAY : first_stage;
            end
         end
         ST_DELAY: begin
            if (instr_tick) begin
               next_state = first_stage;
            end
         end
         ST_PRE: begin
            if (cnt_done) begin
               next_state = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (cnt_done) begin
               next_state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (tick && idx == '0) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (kill) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign cnt_load = (next_state != state) && (next_state == ST_PRE || next_state == ST_ACQ);
   assign cnt_value = (next_state == ST_PRE) ? pre_cycles : PRE_W'(ACQ_TICKS);

   acs_tick_counter #(
      .W(PRE_W)
   ) u_stage_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(cnt_load),
      .value_i(cnt_value),
      .tick_i(tick),
      .done_o(cnt_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Successive approximation, one bit per stage tick

   assign done_evt = (state == ST_CONV) && tick && (idx == '0) && !kill;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res <= '0;
         idx <= '0;
      end else if (state != ST_CONV && next_state == ST_CONV) begin
         res <= {1'b1, {(RES_W - 1){1'b0}}};
         idx <= IDX_W'(RES_W - 1);
      end else if (state == ST_CONV && tick && !kill) begin
         res[idx] <= comp_i;
         if (idx != '0) begin
            res[idx - 1'b1] <= 1'b1;
            idx <= idx - 1'b1;
         end
      end
   end

   assign partial = fill_partial(res, idx);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result <= '0;
      end else if (done_evt) begin
         result <= {res[RES_W-1:1], comp_i};
      end else if (kill && state == ST_CONV) begin
         result <= partial;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep handling and power

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_q <= 1'b0;
         pd <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         sleep_q <= sleep_i;
         wake_o <= done_evt && sleep_i && irq_mask[IRQ_DONE_BIT];
         if ((done_evt && sleep_i && !irq_mask[IRQ_DONE_BIT]) || (sleep_rise && !ctrl.rc_sel)) begin
            pd <= 1'b1;
         end else if (!sleep_i) begin
            pd <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts: only the bits actually returned are cleared by the read

   assign irq_set = {kill, done_evt};
   assign irq_clr = (acc && !wb_we_i && reg_hit(wb_adr_i, ADDR_IRQ_STAT)) ? wb_dat_o[IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= IRQ_RST;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Status and datapath outputs

   always_comb begin
      stage_stat.active = ctrl.go;
      stage_stat.stage = (state == ST_PRE) ? STAGE_PRE :
                         (state == ST_ACQ) ? STAGE_ACQ :
                         (state == ST_CONV) ? STAGE_CONV : STAGE_NONE;
   end
   assign sar_code_o = res;
   assign precharge_o = (state == ST_PRE);
   assign sample_o = (state == ST_ACQ);
   assign converting_o = (state == ST_CONV);
   assign powered_o = ctrl.enable && !pd;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_rc_start;
      start && ctrl.rc_sel;
   endsequence
   sequence s_delay_done;
      state == ST_DELAY && instr_tick && !kill;
   endsequence

   property p_sw_start;
      (state == ST_IDLE && sw_start) |=> (ctrl.go && state != ST_IDLE);
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("start write did not begin sequence");

   property p_done;
      done_evt |=> (!ctrl.go && irq_stat[IRQ_DONE_BIT] && (result >> 1) == ($past(res) >> 1));
   endproperty
   a_done: assert property (p_done) else $error("completion effects missing");

   property p_abort;
      (kill && state == ST_CONV) |=> (result == $past(partial) && state == ST_IDLE);
   endproperty
   a_abort: assert property (p_abort) else $error("abort result wrong");

   property p_reset;
      @(posedge clk_i) disable iff (1'b0) rst_i |=> (state == ST_IDLE && ctrl == CTRL_RST && !powered_o);
   endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");

   property p_rc_delay;
      s_rc_start |=> state == ST_DELAY;
   endproperty
   a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");

   property p_delay_leave;
      s_delay_done |=> (state == ST_PRE || state == ST_ACQ);
   endproperty
   a_delay_leave: assert property (p_delay_leave) else $error("delay stage stuck");

   property p_wake;
      (done_evt && sleep_i && irq_mask[IRQ_DONE_BIT]) |=> wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on completion");

   property p_sleep_off;
      (done_evt && sleep_i && !irq_mask[IRQ_DONE_BIT] && !wr_ctrl0) |=> (!powered_o && ctrl.enable);
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("not powered down after sleep completion");

   property p_sleep_abort;
      (sleep_kill && !wr_ctrl0) |=> (state == ST_IDLE && !powered_o && ctrl.enable && !ctrl.go);
   endproperty
   a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

   property p_trigger;
      (state == ST_IDLE && ctrl.enable && trig_hit) |=> ctrl.go;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger did not start");

   property p_pre_skip;
      (start && !ctrl.rc_sel && pre_cycles == '0) |=> state == ST_ACQ;
   endproperty
   a_pre_skip: assert property (p_pre_skip) else $error("zero precharge not skipped");

   property p_rc_timing;
      (state == ST_PRE && ctrl.rc_sel && !rc_tick_i && !kill) |=> state == ST_PRE;
   endproperty
   a_rc_timing: assert property (p_rc_timing) else $error("precharge moved without rc tick");

   property p_busy;
      (state != ST_IDLE) |-> ctrl.go;
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit low in sequence");

endmodule

`default_nettype wire

//--- verif/acs_far_side.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Comparator and dedicated RC oscillator beside the converter
module acs_far_side
   import acs_pkg::*;
#(
   parameter int RC_DIV = 6
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [RES_W_DEF-1:0] code_i,
   input wire logic [RES_W_DEF-1:0] level_i,
   output logic comp_o,
   output logic rc_tick_o
);
   int cnt;
   // Keep the trial bit while the input is at or above it
   assign comp_o = (code_i <= level_i);
   // Period unrelated to the instruction divider on purpose
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         rc_tick_o <= 1'b0;
      end else begin
         cnt <= (cnt == RC_DIV - 1) ? 0 : cnt + 1;
         rc_tick_o <= (cnt == RC_DIV - 1);
      end
   end
endmodule
`default_nettype wire

//--- verif/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_tb;
   import acs_pkg::*;
   localparam int RC_DIV = 6;
   logic clk_i, rst_i, cyc, stb, we, sleep;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, rd, wb_dat_o, seed;
   logic [4:0] trig;
   logic [9:0] level, res, code;
   logic wb_ack_o, comp, tick, pre_o, powered_o, wake_o, irq_o, conv_o, acq_o;
   int n_fail, cmp_count, pre_len, acq_len, conv_len, n_wake, i;
   ////////////////////////////////////////////////////////////////////
   acs_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trig_i(trig),
      .rc_tick_i(tick), .sleep_i(sleep), .comp_i(comp), .sar_code_o(code),
      .precharge_o(pre_o), .sample_o(acq_o), .converting_o(conv_o),
      .powered_o(powered_o), .wake_o(wake_o), .irq_o(irq_o));
   acs_far_side #(.RC_DIV(RC_DIV)) far (.clk_i(clk_i), .rst_i(rst_i),
      .code_i(code), .level_i(level), .comp_o(comp), .rc_tick_o(tick));
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (pre_o === 1'b1) pre_len <= pre_len + 1;
      if (acq_o === 1'b1) acq_len <= acq_len + 1;
      if (conv_o === 1'b1) conv_len <= conv_len + 1;
      if (wake_o === 1'b1) n_wake <= n_wake + 1;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Tick phase is free, so allow one unit of slack below
   function automatic logic pre_ok(input int p, input int len, input int u);
      if (p == 0) return len == 0;
      return len >= (p - 1) * u && len <= p * u + 1;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      // Only the watchdog ends a wait for ack
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rdr(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic wait_idle;
      rdr(ADDR_CTRL0);
      while (rd[1] !== 1'b0) begin
         rdr(ADDR_CTRL0);
      end
   endtask
   task automatic rd_res;
      rdr(ADDR_RES_HIGH);
      res[9:8] = rd[1:0];
      rdr(ADDR_RES_LOW);
      res[7:0] = rd[7:0];
   endtask
   task automatic conv(input logic [9:0] v, input logic [6:0] p, input logic rc);
      level <= v;
      wr(ADDR_PRE, {25'h0, p});
      wr(ADDR_CTRL0, {29'h0, rc, 2'h1});
      pre_len = 0;
      acq_len = 0;
      conv_len = 0;
      wr(ADDR_CTRL0, {29'h0, rc, 2'h3});
      rdr(ADDR_STAGE);
      chk(rd[2], 1'b1);
      wait_idle;
      chk(rd[2:0], {rc, 2'h1});
      chk(irq_o, 1'b1);
      rd_res;
      chk(res, v);
      chk(pre_ok(p, pre_len, rc ? RC_DIV : INSTR_CLKS), 1'b1);
      chk(pre_ok(ACQ_TICKS_DEF, acq_len, rc ? RC_DIV : INSTR_CLKS), 1'b1);
      chk(pre_ok(RES_W_DEF, conv_len, rc ? RC_DIV : INSTR_CLKS), 1'b1);
      rdr(ADDR_IRQ_STAT);
      chk(rd[0], 1'b1);
      rdr(ADDR_IRQ_STAT);
      chk(rd, 32'h0);
      chk(irq_o, 1'b0);
   endtask
   task automatic pulse(input int j);
      @(posedge clk_i);
      trig <= 5'h01 << j;
      @(posedge clk_i);
      trig <= 5'h00;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge clk_i);
      n_fail++;
      print_verdict;
   end
   initial begin
      {cyc, stb, we, sleep, adr, dat, trig, level} = '0;
      sel = 4'hf;
      rst_i = 1'b1;
      seed = 32'hae7c;
      n_fail = 0;
      cmp_count = 0;
      pre_len = 0;
      n_wake = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 9; i++) begin
         rdr(8'(i * 4));
         chk(rd, 32'h0);
      end
      $display("test reset_values done");
      wr(ADDR_IRQ_MASK, 32'h1);
      conv(10'h000, 7'h00, 1'b0);
      conv(10'h3ff, 7'h7f, 1'b0);
      for (i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         conv(seed[9:0], {4'h0, seed[12:10]}, i[0]);
      end
      $display("test conversions done");
      level <= 10'h200;
      wr(ADDR_PRE, 32'h0);
      wr(ADDR_CTRL0, 32'h1);
      wr(ADDR_CTRL0, 32'h3);
      while (conv_o !== 1'b1) begin
         @(posedge clk_i);
      end
      repeat (16) @(posedge clk_i);
      wr(ADDR_CTRL0, 32'h1);
      rdr(ADDR_CTRL0);
      chk(rd[2:0], 3'h1);
      rd_res;
      chk(res, 10'h200);
      rdr(ADDR_IRQ_STAT);
      chk(rd[1:0], 2'h2);
      $display("test abort done");
      for (i = 0; i < TRIG_SRC_N; i++) begin
         wr(ADDR_CTRL2, i);
         // An unselected source must not start a run; the selected one must
         pulse((i + 1) % TRIG_SRC_N);
         rdr(ADDR_CTRL0);
         chk(rd[1], 1'b0);
         pulse(i);
         rdr(ADDR_CTRL0);
         chk(rd[1], 1'b1);
         wait_idle;
         rdr(ADDR_IRQ_STAT);
         chk(rd[0], 1'b1);
      end
      // Selects past the last source must ignore every trigger line
      wr(ADDR_CTRL2, 32'h7);
      @(posedge clk_i);
      trig <= 5'h1f;
      @(posedge clk_i);
      trig <= 5'h00;
      rdr(ADDR_CTRL0);
      chk(rd[1], 1'b0);
      $display("test triggers done");
      wr(ADDR_CTRL0, 32'h3);
      @(posedge clk_i);
      sleep <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(powered_o, 1'b0);
      rdr(ADDR_CTRL0);
      chk(rd[2:0], 3'h1);
      sleep <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(powered_o, 1'b1);
      rdr(ADDR_IRQ_STAT);
      n_wake = 0;
      wr(ADDR_CTRL0, 32'h5);
      wr(ADDR_CTRL0, 32'h7);
      sleep <= 1'b1;
      wait_idle;
      chk(n_wake, 1);
      sleep <= 1'b0;
      wr(ADDR_IRQ_MASK, 32'h0);
      wr(ADDR_CTRL0, 32'h7);
      sleep <= 1'b1;
      wait_idle;
      chk(rd[2:0], 3'h5);
      chk(powered_o, 1'b0);
      chk(n_wake, 1);
      sleep <= 1'b0;
      $display("test sleep done");
      wr(ADDR_IRQ_MASK, 32'h3);
      wr(ADDR_CTRL0, 32'h3);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdr(ADDR_CTRL0);
      chk(rd, 32'h0);
      rdr(ADDR_IRQ_MASK);
      chk(rd, 32'h0);
      chk(powered_o, 1'b0);
      $display("test mid_reset done");
      print_verdict;
   end
endmodule
`default_nettype wire
